// file: logic/btcd_regs.vh
`ifndef BTCD_REGS_VH
`define BTCD_REGS_VH
// Operation selects
`define BTCD_OP_W            5
`define BTCD_OP_NOP          5'h00
`define BTCD_OP_SKIP_CLR     5'h01
`define BTCD_OP_SKIP_SET     5'h02
`define BTCD_OP_TEST_Z       5'h03
`define BTCD_OP_TEST_C       5'h04
`define BTCD_OP_TSET_Z       5'h05
`define BTCD_OP_TSET_C       5'h06
`define BTCD_OP_CALL_LIT     5'h07
`define BTCD_OP_CALL_IND     5'h08
`define BTCD_OP_CLEAR        5'h09
`define BTCD_OP_CLEAR_ACC    5'h0A
`define BTCD_OP_WDT_CLEAR    5'h0B
`define BTCD_OP_COMPARE      5'h0C
`define BTCD_OP_COMPARE_ZERO 5'h0D
`define BTCD_OP_COMPARE_BOR  5'h0E
`define BTCD_OP_SKIP_EQ      5'h0F
`define BTCD_OP_SKIP_GT      5'h10
`define BTCD_OP_SKIP_LT      5'h11
`define BTCD_OP_SKIP_NE      5'h12
`define BTCD_OP_DEC_ADJUST   5'h13
`define BTCD_OP_DEC_ONE      5'h14
`define BTCD_OP_DEC_TWO      5'h15
`define BTCD_OP_INT_BLOCK    5'h16
// Status flag positions
`define BTCD_FLAG_C          0
`define BTCD_FLAG_Z          1
`define BTCD_FLAG_OV         2
`define BTCD_FLAG_N          3
`define BTCD_FLAG_DC         4
// Constants
`define BTCD_ZERO_WORD       16'h0000
`define BTCD_DEC_ONE_VAL     16'h0001
`define BTCD_DEC_TWO_VAL     16'h0002
`define BTCD_TOP_PRIO        3'h7
`define BTCD_BCD_LIMIT       4'h9
`define BTCD_BCD_FIX         4'h6
`define BTCD_LIT14_W         14
`define BTCD_ADDR_W          23
// Cycle costs and return offsets
`define BTCD_CYC_ONE         2'h1
`define BTCD_CYC_TWO         2'h2
`define BTCD_CYC_THREE       2'h3
`define BTCD_RET_LIT         23'h000004
`define BTCD_RET_IND         23'h000002
`endif

// file: logic/btcd_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "btcd_regs.vh"
// Subtracts with carry-in; borrow-style flags
module btcd_alu (
	// Operands
	input  wire [15:0] op_a,
	input  wire [15:0] op_b,
	input  wire        carry_in,
	// Result
	output wire [15:0] diff,
	output wire        carry_out,
	output wire        dc_out,
	output wire        ov_out,
	output wire        n_out,
	output wire        z_out
);
	wire [16:0] full;
	wire [4:0]  low;
	// a - b - !cin == a + ~b + cin
	assign full      = {1'b0, op_a} + {1'b0, ~op_b} + {16'h0000, carry_in};
	assign low       = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + {4'h0, carry_in};
	assign diff      = full[15:0];
	assign carry_out = full[16];
	assign dc_out    = low[4];
	assign ov_out    = (op_a[15] ^ op_b[15]) & (op_a[15] ^ full[15]);
	assign n_out     = full[15];
	assign z_out     = (full[15:0] == `BTCD_ZERO_WORD);
endmodule
`default_nettype wire

// file: logic/btcd_exec.v
// Operation
// - skip-if-clear skips next instruction when tested bit is zero; no flags.
// - skip-if-set skips next instruction when tested bit is one; no flags.
// - bit tests copy bit to C or its complement to Z; test-then-set also writes one.
// - literal call two words two cycles; indirect call one word two cycles.
// - clear writes zero without flags; accumulator clear clears OA SA or OB SB, for the selected accumulator only.
// - watchdog clear resets count and updates timeout and sleep indications.
// - compare subtracts second from first, discards result, updates C DC N OV Z.
// - compare-with-zero compares operand against zero, updates five flags.
// - compare-with-borrow subtracts operand and inverted carry, updates five flags.
// - compare-and-skip skips on eq gt lt ne relation; no flags.
// - decimal adjust corrects to packed BCD, affects only carry.
// - decrement subtracts one or two, writes result, updates five flags.
// - timed interrupt block holds interrupts for 14-bit literal cycle count.
// - level 7 interrupts and traps stay enabled during the block.
`timescale 1ns/1ps
`default_nettype none
`include "btcd_regs.vh"
module btcd_exec #(
	parameter LIT14_W = `BTCD_LIT14_W
) (
	// Clock and reset
	input  wire                    ref_clk,
	input  wire                    reset_n,
	// Decoded instruction
	input  wire                    issue,
	input  wire [`BTCD_OP_W-1:0]   op_sel,
	input  wire [15:0]             operand_a,
	input  wire [15:0]             operand_b,
	input  wire [3:0]              bit_sel,
	input  wire [`BTCD_ADDR_W-1:0] call_target,
	input  wire [`BTCD_ADDR_W-1:0] pc_in,
	input  wire                    next_two_word,
	input  wire                    acc_sel_b,
	input  wire [LIT14_W-1:0]      block_count,
	// Status in
	input  wire [4:0]              status_in,
	// Interrupt request
	input  wire                    irq_req,
	input  wire [2:0]              irq_prio,
	input  wire                    trap_req,
	// Results
	output reg                     busy_r,
	output reg                     result_we_r,
	output reg  [15:0]             result_r,
	output reg  [4:0]              status_r,
	output reg                     skip_r,
	output reg  [1:0]              cycles_r,
	// Call
	output reg                     push_we_r,
	output reg  [`BTCD_ADDR_W-1:0] push_data_r,
	output reg                     jump_r,
	output reg  [`BTCD_ADDR_W-1:0] jump_addr_r,
	// Accumulator flags
	output reg                     acc_a_overflow_flag_r,
	output reg                     acc_b_overflow_flag_r,
	output reg                     acc_a_saturation_flag_r,
	output reg                     acc_b_saturation_flag_r,
	// Watchdog and power
	output reg                     wdt_reset_r,
	output reg                     watchdog_timeout_flag_r,
	output reg                     sleep_flag_r,
	// Interrupt gate
	output reg                     irq_take_r,
	output reg                     block_active_r
);
	localparam ST_IDLE = 2'h0;
	localparam ST_HOLD = 2'h1;

	reg [1:0]         state_r;
	reg [1:0]         state_nxt;
	reg [1:0]         hold_r;
	reg [1:0]         hold_nxt;
	reg [LIT14_W-1:0] block_cnt_r;

	wire [15:0] alu_a;
	wire [15:0] alu_b;
	wire        alu_cin;
	wire [15:0] alu_diff;
	wire        alu_c;
	wire        alu_dc;
	wire        alu_ov;
	wire        alu_n;
	wire        alu_z;
	wire        tbit;

	// Skip length depends on width of skipped instruction
	function [1:0] skip_cycles;
		input two_word;
		begin
			skip_cycles = two_word ? `BTCD_CYC_THREE : `BTCD_CYC_TWO;
		end
	endfunction

	function [4:0] flags5;
		input c;
		input dc;
		input n;
		input ov;
		input z;
		begin
			flags5 = 5'h00;
			flags5[`BTCD_FLAG_C]  = c;
			flags5[`BTCD_FLAG_DC] = dc;
			flags5[`BTCD_FLAG_N]  = n;
			flags5[`BTCD_FLAG_OV] = ov;
			flags5[`BTCD_FLAG_Z]  = z;
		end
	endfunction

	assign tbit = operand_a[bit_sel];

	// Load on the block op, else count down to zero
	wire [LIT14_W-1:0] block_nxt;
	assign block_nxt = (issue && !busy_r && op_sel == `BTCD_OP_INT_BLOCK) ? block_count :
		(block_cnt_r != {LIT14_W{1'b0}}) ? block_cnt_r - {{(LIT14_W-1){1'b0}}, 1'b1} :
		{LIT14_W{1'b0}};

	// Operand steering for the shared subtractor
	assign alu_a = operand_a;
	assign alu_b = (op_sel == `BTCD_OP_COMPARE_ZERO) ? `BTCD_ZERO_WORD :
		(op_sel == `BTCD_OP_DEC_ONE) ? `BTCD_DEC_ONE_VAL :
		(op_sel == `BTCD_OP_DEC_TWO) ? `BTCD_DEC_TWO_VAL : operand_b;
	assign alu_cin = (op_sel == `BTCD_OP_COMPARE_BOR) ? status_in[`BTCD_FLAG_C] : 1'b1;

	btcd_alu u_alu (
		.op_a      (alu_a),
		.op_b      (alu_b),
		.carry_in  (alu_cin),
		.diff      (alu_diff),
		.carry_out (alu_c),
		.dc_out    (alu_dc),
		.ov_out    (alu_ov),
		.n_out     (alu_n),
		.z_out     (alu_z)
	);

	// Decimal adjust of low byte
	reg [8:0] daw_val;
	reg       daw_c;
	always @* begin
		daw_val = {1'b0, operand_a[7:0]};
		daw_c   = status_in[`BTCD_FLAG_C];
		if (daw_val[3:0] > `BTCD_BCD_LIMIT || status_in[`BTCD_FLAG_DC]) begin
			daw_val = daw_val + {5'h00, `BTCD_BCD_FIX};
		end
		if (daw_val[8] || daw_val[7:4] > `BTCD_BCD_LIMIT || status_in[`BTCD_FLAG_C]) begin
			daw_val = daw_val + {1'b0, `BTCD_BCD_FIX, 4'h0};
		end
		daw_c = daw_c | daw_val[8];
	end

	// Sequencing of multi-cycle operations
	always @* begin
		state_nxt = state_r;
		hold_nxt  = hold_r;
		case (state_r)
			ST_IDLE: begin
				if (issue && hold_r > 2'h1) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (hold_r <= 2'h1) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	reg       skip_now;
	reg [1:0] cyc_now;
	always @* begin
		skip_now = 1'b0;
		case (op_sel)
			`BTCD_OP_SKIP_CLR: skip_now = ~tbit;
			`BTCD_OP_SKIP_SET: skip_now = tbit;
			`BTCD_OP_SKIP_EQ:  skip_now = (operand_a == operand_b);
			`BTCD_OP_SKIP_GT:  skip_now = ($signed(operand_a) > $signed(operand_b));
			`BTCD_OP_SKIP_LT:  skip_now = ($signed(operand_a) < $signed(operand_b));
			`BTCD_OP_SKIP_NE:  skip_now = (operand_a != operand_b);
			default:           skip_now = 1'b0;
		endcase
		if (skip_now) begin
			cyc_now = skip_cycles(next_two_word);
		end else if (op_sel == `BTCD_OP_CALL_LIT || op_sel == `BTCD_OP_CALL_IND) begin
			cyc_now = `BTCD_CYC_TWO;
		end else begin
			cyc_now = `BTCD_CYC_ONE;
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r                 <= ST_IDLE;
			hold_r                  <= 2'h0;
			busy_r                  <= 1'b0;
			result_we_r             <= 1'b0;
			result_r                <= `BTCD_ZERO_WORD;
			status_r                <= 5'h00;
			skip_r                  <= 1'b0;
			cycles_r                <= 2'h0;
			push_we_r               <= 1'b0;
			push_data_r             <= {`BTCD_ADDR_W{1'b0}};
			jump_r                  <= 1'b0;
			jump_addr_r             <= {`BTCD_ADDR_W{1'b0}};
			acc_a_overflow_flag_r   <= 1'b0;
			acc_b_overflow_flag_r   <= 1'b0;
			acc_a_saturation_flag_r <= 1'b0;
			acc_b_saturation_flag_r <= 1'b0;
			wdt_reset_r             <= 1'b0;
			watchdog_timeout_flag_r <= 1'b0;
			sleep_flag_r            <= 1'b0;
			irq_take_r              <= 1'b0;
			block_active_r          <= 1'b0;
			block_cnt_r             <= {LIT14_W{1'b0}};
		end else begin
			state_r     <= state_nxt;
			result_we_r <= 1'b0;
			skip_r      <= 1'b0;
			push_we_r   <= 1'b0;
			jump_r      <= 1'b0;
			wdt_reset_r <= 1'b0;
			if (hold_r != 2'h0) begin
				hold_r <= hold_r - 2'h1;
			end
			// Busy falls so the next op is taken on its due edge
			busy_r <= (hold_r > `BTCD_CYC_TWO);
			// Interrupt block counts down one per cycle
			block_cnt_r    <= block_nxt;
			block_active_r <= (block_nxt != {LIT14_W{1'b0}});
			irq_take_r     <= trap_req ||
				(irq_req && (irq_prio == `BTCD_TOP_PRIO || block_nxt == {LIT14_W{1'b0}}));
			if (issue && !busy_r) begin
				status_r <= status_in;
				hold_r   <= cyc_now;
				busy_r   <= (cyc_now > `BTCD_CYC_ONE);
				cycles_r <= cyc_now;
				skip_r   <= skip_now;
				case (op_sel)
					`BTCD_OP_TEST_Z: status_r[`BTCD_FLAG_Z] <= ~tbit;
					`BTCD_OP_TEST_C: status_r[`BTCD_FLAG_C] <= tbit;
					`BTCD_OP_TSET_Z: begin
						status_r[`BTCD_FLAG_Z] <= ~tbit;
						result_r               <= operand_a | (16'h0001 << bit_sel);
						result_we_r            <= 1'b1;
					end
					`BTCD_OP_TSET_C: begin
						status_r[`BTCD_FLAG_C] <= tbit;
						result_r               <= operand_a | (16'h0001 << bit_sel);
						result_we_r            <= 1'b1;
					end
					`BTCD_OP_CALL_LIT, `BTCD_OP_CALL_IND: begin
						push_we_r   <= 1'b1;
						push_data_r <= (op_sel == `BTCD_OP_CALL_LIT) ?
							pc_in + `BTCD_RET_LIT : pc_in + `BTCD_RET_IND;
						jump_r      <= 1'b1;
						jump_addr_r <= (op_sel == `BTCD_OP_CALL_LIT) ?
							call_target : {7'h00, operand_a};
					end
					`BTCD_OP_CLEAR: begin
						result_r    <= `BTCD_ZERO_WORD;
						result_we_r <= 1'b1;
					end
					`BTCD_OP_CLEAR_ACC: begin
						if (acc_sel_b) begin
							acc_b_overflow_flag_r   <= 1'b0;
							acc_b_saturation_flag_r <= 1'b0;
						end else begin
							acc_a_overflow_flag_r   <= 1'b0;
							acc_a_saturation_flag_r <= 1'b0;
						end
					end
					`BTCD_OP_WDT_CLEAR: begin
						wdt_reset_r             <= 1'b1;
						watchdog_timeout_flag_r <= 1'b0;
						sleep_flag_r            <= 1'b0;
					end
					`BTCD_OP_COMPARE, `BTCD_OP_COMPARE_ZERO, `BTCD_OP_COMPARE_BOR: begin
						status_r <= flags5(alu_c, alu_dc, alu_n, alu_ov, alu_z);
					end
					`BTCD_OP_DEC_ADJUST: begin
						result_r    <= {operand_a[15:8], daw_val[7:0]};
						result_we_r <= 1'b1;
						status_r[`BTCD_FLAG_C] <= daw_c;
					end
					`BTCD_OP_DEC_ONE, `BTCD_OP_DEC_TWO: begin
						result_r    <= alu_diff;
						result_we_r <= 1'b1;
						status_r    <= flags5(alu_c, alu_dc, alu_n, alu_ov, alu_z);
					end
					`BTCD_OP_INT_BLOCK: begin
						block_cnt_r <= block_count;
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: test/btcd_exec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module btcd_exec_chk (
	// Clock, reset, request
	input wire logic        ref_clk, reset_n, issue, next_two_word, trap_req,
	input wire logic [4:0]  op_sel, status_in,
	input wire logic [15:0] operand_a, operand_b,
	input wire logic [3:0]  bit_sel,
	input wire logic [22:0] pc_in,
	input wire logic [2:0]  irq_prio,
	// Results
	input wire logic        busy_r, result_we_r, skip_r, push_we_r, wdt_reset_r,
	input wire logic        irq_take_r, block_active_r,
	input wire logic [15:0] result_r,
	input wire logic [4:0]  status_r,
	input wire logic [1:0]  cycles_r,
	input wire logic [22:0] push_data_r
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire take = issue && !busy_r;
	wire tbit = operand_a[bit_sel];

	a_skip_clear_bit: assert property (take && op_sel == 5'h01 |=> skip_r == !$past(tbit))
		else $error("skip on clear bit wrong");
	a_skip_set_bit: assert property (take && op_sel == 5'h02 |=> skip_r == $past(tbit))
		else $error("skip on set bit wrong");
	a_skip_cost: assert property (skip_r |-> busy_r && cycles_r == ($past(next_two_word) ? 2'h3 : 2'h2))
		else $error("skip cost wrong");
	a_call_return: assert property (take && op_sel == 5'h07 |=>
		push_we_r && push_data_r == $past(pc_in) + 23'h4 ##1 !busy_r)
		else $error("call return address wrong");
	a_clear_zero: assert property (take && op_sel == 5'h09 |=>
		result_we_r && result_r == 16'h0000 && status_r == $past(status_in))
		else $error("clear wrong");
	a_dec_two: assert property (take && op_sel == 5'h15 |=>
		result_r == $past(operand_a) - 16'h0002 && status_r[1] == (result_r == 16'h0000))
		else $error("double decrement wrong");
	a_compare_discard: assert property (take && op_sel == 5'h0C |=>
		!result_we_r && status_r[1] == ($past(operand_a) == $past(operand_b)))
		else $error("compare wrong");
	a_wdt_clear: assert property (take && op_sel == 5'h0B |=> wdt_reset_r)
		else $error("watchdog clear missing");
	a_block_gate: assert property (irq_take_r && block_active_r && $past(block_active_r) |->
		$past(trap_req) || $past(irq_prio) == 3'h7)
		else $error("interrupt passed while blocked");

	cover property (skip_r && cycles_r == 2'h3);
	cover property (push_we_r);
	cover property (irq_take_r && block_active_r);
endmodule
`default_nettype wire

// file: test/btcd_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "btcd_regs.vh"
module btcd_exec_tb;
	localparam logic [15:0] pat = 16'h0401;
	logic        ref_clk, reset_n, issue, next_two_word, acc_sel_b, irq_req, trap_req, bz, t;
	logic        busy_r, result_we_r, skip_r, push_we_r, jump_r, wdt_reset_r;
	logic        irq_take_r, block_active_r;
	logic [4:0]  op_sel, status_in, status_r, e;
	logic [15:0] operand_a, operand_b, result_r;
	logic [3:0]  bit_sel, bs;
	logic [22:0] call_target, pc_in, push_data_r, jump_addr_r;
	logic [13:0] block_count;
	logic [2:0]  irq_prio;
	logic [1:0]  cycles_r;
	int          i, k, cyc, n_errors, check_count;

	btcd_exec i_dut (.ref_clk, .reset_n, .issue, .op_sel, .operand_a, .operand_b, .bit_sel,
		.call_target, .pc_in, .next_two_word, .acc_sel_b, .block_count, .status_in,
		.irq_req, .irq_prio, .trap_req, .busy_r, .result_we_r, .result_r, .status_r, .skip_r,
		.cycles_r, .push_we_r, .push_data_r, .jump_r, .jump_addr_r,
		.acc_a_overflow_flag_r(), .acc_b_overflow_flag_r(), .acc_a_saturation_flag_r(),
		.acc_b_saturation_flag_r(), .wdt_reset_r, .watchdog_timeout_flag_r(),
		.sleep_flag_r(), .irq_take_r, .block_active_r);

	function automatic logic [1:0] cost(input logic s, input logic tw);
		return s ? 2'h2 + {1'b0, tw} : 2'h1;
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task end_sim;
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Holds the request until an edge sees busy low
	task run(input logic [4:0] op, input logic [15:0] a, b, input logic [3:0] s, input logic tw);
		op_sel = op;
		operand_a = a;
		operand_b = b;
		bit_sel = s;
		next_two_word = tw;
		issue = 1'b1;
		do begin
			bz = busy_r;
			@(posedge ref_clk);
			#1;
		end while (bz !== 1'b0);
	endtask

	task alu(input logic [4:0] op, input logic [15:0] a, b, input logic [4:0] si,
		input logic we, input logic [15:0] r, input logic [4:0] s);
		status_in = si;
		run(op, a, b, 4'h0, 1'b0);
		chk(result_we_r, we);
		chk(status_r, s);
		if (we)
			chk(result_r, r);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			end_sim;
		end
	end

	initial begin
		{issue, next_two_word, acc_sel_b, irq_req, trap_req} = 5'h00;
		{op_sel, status_in, operand_a, operand_b, bit_sel} = 46'h0;
		{call_target, pc_in, block_count, irq_prio} = 63'h0;
		reset_n = 1'b0;
		repeat (20) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		status_in = 5'h15;
		for (i = 0; i < 4; i++) begin
			bs = 4'(i * 5);
			t = pat[bs];
			run(`BTCD_OP_SKIP_CLR, pat, 16'h0000, bs, i[0]);
			chk(skip_r, !t);
			chk(cycles_r, cost(!t, i[0]));
			chk(status_r, status_in);
			run(`BTCD_OP_SKIP_SET, pat, 16'h0000, bs, i[0]);
			chk(skip_r, t);
			chk(cycles_r, cost(t, i[0]));
		end
		for (k = 3; k < 7; k++) begin
			bs = k[0] ? 4'hA : 4'h5;
			t = pat[bs];
			e = status_in;
			if (k[0])
				e[1] = !t;
			else
				e[0] = t;
			run(5'(k), pat, 16'h0000, bs, 1'b0);
			chk(status_r, e);
			if (k > 4)
				chk(result_r, pat | (16'h0001 << bs));
		end
		pc_in = 23'h7FFFF0;
		call_target = 23'h012345;
		run(`BTCD_OP_CALL_LIT, 16'h0000, 16'h0000, 4'h0, 1'b0);
		chk({push_we_r, jump_r, push_data_r}, {2'h3, 23'h7FFFF4});
		chk({cycles_r, jump_addr_r}, {2'h2, 23'h012345});
		run(`BTCD_OP_CALL_IND, 16'h1234, 16'h0000, 4'h0, 1'b0);
		chk({cycles_r, push_data_r}, {2'h2, 23'h7FFFF2});
		chk({jump_r, jump_addr_r}, {1'b1, 23'h001234});
		alu(`BTCD_OP_CLEAR, 16'h1234, 16'h0000, 5'h1F, 1'b1, 16'h0000, 5'h1F);
		alu(`BTCD_OP_CLEAR_ACC, 16'h1234, 16'h0000, 5'h1F, 1'b0, 16'h0000, 5'h1F);
		alu(`BTCD_OP_COMPARE, 16'h0005, 16'h0007, 5'h00, 1'b0, 16'h0000, 5'h08);
		alu(`BTCD_OP_COMPARE, 16'h8000, 16'h0001, 5'h00, 1'b0, 16'h0000, 5'h05);
		alu(`BTCD_OP_COMPARE_BOR, 16'h0005, 16'h0005, 5'h00, 1'b0, 16'h0000, 5'h08);
		alu(`BTCD_OP_COMPARE_BOR, 16'h0005, 16'h0005, 5'h03, 1'b0, 16'h0000, 5'h13);
		alu(`BTCD_OP_COMPARE_ZERO, 16'h0000, 16'h0000, 5'h00, 1'b0, 16'h0000, 5'h13);
		alu(`BTCD_OP_DEC_ONE, 16'h0000, 16'h0000, 5'h00, 1'b1, 16'hFFFF, 5'h08);
		alu(`BTCD_OP_DEC_TWO, 16'h8001, 16'h0000, 5'h00, 1'b1, 16'h7FFF, 5'h05);
		alu(`BTCD_OP_DEC_ADJUST, 16'h003C, 16'h0000, 5'h0A, 1'b1, 16'h0042, 5'h0A);
		for (k = 15; k < 19; k++) begin
			t = (k > 16);
			run(5'(k), 16'hFFFF, 16'h0001, 4'h0, 1'b1);
			chk({skip_r, status_r}, {t, status_in});
			chk(cycles_r, cost(t, 1'b1));
		end
		run(`BTCD_OP_WDT_CLEAR, 16'h0000, 16'h0000, 4'h0, 1'b0);
		chk(wdt_reset_r, 1'b1);
		block_count = 14'h0005;
		irq_prio = 3'h3;
		run(`BTCD_OP_INT_BLOCK, 16'h0000, 16'h0000, 4'h0, 1'b0);
		issue = 1'b0;
		irq_req = 1'b1;
		chk(block_active_r, 1'b1);
		@(posedge ref_clk);
		#1;
		chk(irq_take_r, 1'b0);
		irq_prio = 3'h7;
		repeat (2) @(posedge ref_clk);
		#1;
		chk(irq_take_r, 1'b1);
		irq_prio = 3'h3;
		repeat (8) @(posedge ref_clk);
		#1;
		chk({block_active_r, irq_take_r}, 2'h1);
		end_sim;
	end
endmodule

bind btcd_exec btcd_exec_chk i_chk (.ref_clk, .reset_n, .issue, .next_two_word, .trap_req,
	.op_sel, .status_in, .operand_a, .operand_b, .bit_sel, .pc_in, .irq_prio, .busy_r,
	.result_we_r, .skip_r, .push_we_r, .wdt_reset_r, .irq_take_r, .block_active_r,
	.result_r, .status_r, .cycles_r, .push_data_r);
`default_nettype wire
